// *** hdl/rfi_top.sv ***
/*
 * Regulator fault bypass, host reset gating at power up and two-level
 * interrupt aggregation, with an I2C register target.
 * Assumes all event and monitor inputs come from logic on clk; only the
 * I2C pins are asynchronous and are synchronised here.
 */
`include "rfi_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rfi_top #(
	parameter int unsigned HOLD_CYCLES = `RFI_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// I2C target pins
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe_n,
	// One-time-programmable configuration
	input wire rfi_pkg::rfi_fault_s otp_skip,
	input wire logic startup_pg_gate_cfg,
	// Regulator state and monitors
	input wire rfi_pkg::rfi_rail_s rail_enabled,
	input wire rfi_pkg::rfi_rail_s rail_blank_done,
	input wire rfi_pkg::rfi_rail_s internal_power_ok,
	input wire rfi_pkg::rfi_fault_s fault_raw,
	// Other interrupt sources
	input wire logic [7:0] status_evt,
	input wire logic [7:0] thermal_evt,
	input wire logic [7:0] mode_evt,
	input wire logic [7:0] button_evt,
	input wire logic early_warn_evt,
	// Power-up sequencer
	input wire logic seq_at_reset_slot,
	output logic host_reset_out_n,
	output logic seq_hold,
	output logic seq_abort,
	output rfi_pkg::rfi_rail_s abort_off,
	// Protection and pins
	output rfi_pkg::rfi_fault_s rail_protect,
	output logic power_good_pin,
	output logic irq_out_n
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Bits of each group that have a live view; others read zero.
	function automatic rfi_pkg::rfi_byte_t live_mask(input int g);
		unique case (g)
			0: live_mask = 8'h07;
			2: live_mask = 8'h00;
			9: live_mask = 8'h81;
			default: live_mask = 8'hff;
		endcase
	endfunction : live_mask

	// True when an unmasked latch is set in the group.
	function automatic logic pending(input rfi_pkg::rfi_byte_t l, input rfi_pkg::rfi_byte_t m);
		pending = |(l & ~m);
	endfunction : pending

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	rfi_pkg::rfi_byte_t latch_reg [`RFI_NUM_GROUPS], mask_reg [`RFI_NUM_GROUPS];
	rfi_pkg::rfi_byte_t evt_d_reg [`RFI_NUM_GROUPS], evt_raw [`RFI_NUM_GROUPS];
	rfi_pkg::rfi_byte_t evt_q [`RFI_NUM_GROUPS];
	rfi_pkg::rfi_fault_s skip_reg, fault_q, protect_next;
	logic load_pend_reg, cfg_reg, ewarn_reg, ewarn_d_reg, host_rst_n_reg, all_ok;
	logic [7:0] summary_reg, sum_next;
	rfi_pkg::rfi_seq_e seq_reg;
	logic [16:0] hold_cnt_reg;
	// I2C
	logic scl_m_reg, scl_s_reg, scl_d_reg;
	logic sda_m_reg, sda_s_reg, sda_d_reg;
	logic scl_rise, scl_fall, i2c_start, i2c_stop;
	rfi_pkg::rfi_i2c_e i2c_reg;
	logic [3:0] bit_cnt_reg;
	logic ack_reg, rw_oe_n_reg, wr_stb_reg;
	rfi_pkg::rfi_byte_t shift_reg, ptr_reg, rd_data, wr_addr_reg, wr_data_reg;

	// ---------------------------------------------------------------
	// Fault qualification
	// ---------------------------------------------------------------
	// Voltage monitors are blind until host reset is released and the
	// regulator's blanking is over; current limit counts once enabled.
	always_comb begin
		fault_q.curlim = fault_raw.curlim & rail_enabled;
		fault_q.undervolt = fault_raw.undervolt & rail_enabled & rail_blank_done
			& {11{host_rst_n_reg}};
		fault_q.overvolt = fault_raw.overvolt & rail_enabled & rail_blank_done
			& {11{host_rst_n_reg}};
		protect_next = fault_q & ~skip_reg;
	end

	// Protection requests go to the counter, timer and disable logic;
	// only unbypassed voltage faults pull the power-good pin low.
	always_ff @(posedge clk) begin
		if (reset) begin
			rail_protect <= '0;
			power_good_pin <= 1'b0;
		end else begin
			rail_protect <= protect_next;
			power_good_pin <= ~|{protect_next.undervolt, protect_next.overvolt};
		end
	end

	// ---------------------------------------------------------------
	// Configuration load
	// ---------------------------------------------------------------
	// OTP defaults are taken on the first clock after reset, so the
	// skip bits never depend on a port during reset itself.
	always_ff @(posedge clk) begin
		if (reset) begin
			load_pend_reg <= 1'b1;
			cfg_reg <= 1'b0;
			skip_reg <= '0;
		end else if (load_pend_reg) begin
			load_pend_reg <= 1'b0;
			cfg_reg <= startup_pg_gate_cfg;
			skip_reg <= otp_skip;
		end else if (wr_stb_reg) begin
			unique case (wr_addr_reg)
				`RFI_BUCK_CURLIM_SKIP_OFF: skip_reg.curlim.buck <= wr_data_reg[6:0];
				`RFI_LINEAR_CURLIM_SKIP_OFF: skip_reg.curlim.linear <= wr_data_reg[3:0];
				`RFI_BUCK_UNDERVOLT_SKIP_OFF: skip_reg.undervolt.buck <= wr_data_reg[6:0];
				`RFI_LINEAR_UNDERVOLT_SKIP_OFF: skip_reg.undervolt.linear <= wr_data_reg[3:0];
				`RFI_BUCK_OVERVOLT_SKIP_OFF: skip_reg.overvolt.buck <= wr_data_reg[6:0];
				`RFI_LINEAR_OVERVOLT_SKIP_OFF: skip_reg.overvolt.linear <= wr_data_reg[3:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Power-up reset gating
	// ---------------------------------------------------------------
	assign all_ok = &(internal_power_ok | ~rail_enabled);

	// The sequencer waits for the release slot, then either releases at
	// once, or holds for the window and aborts if power never comes good.
	always_ff @(posedge clk) begin
		if (reset) begin
			seq_reg <= rfi_pkg::SEQ_WAIT;
			hold_cnt_reg <= '0;
			host_rst_n_reg <= 1'b0;
			seq_abort <= 1'b0;
			seq_hold <= 1'b0;
			abort_off <= '0;
		end else begin
			unique case (seq_reg)
				rfi_pkg::SEQ_WAIT: begin
					if (seq_at_reset_slot && !load_pend_reg) begin
						if (!cfg_reg || all_ok) begin
							seq_reg <= rfi_pkg::SEQ_RUN;
							host_rst_n_reg <= 1'b1;
						end else begin
							seq_reg <= rfi_pkg::SEQ_HOLD;
							seq_hold <= 1'b1;
							hold_cnt_reg <= '0;
						end
					end
				end
				rfi_pkg::SEQ_HOLD: begin
					if (all_ok) begin
						seq_reg <= rfi_pkg::SEQ_RUN;
						host_rst_n_reg <= 1'b1;
						seq_hold <= 1'b0;
					end else if (hold_cnt_reg == 17'(HOLD_CYCLES - 1)) begin
						seq_reg <= rfi_pkg::SEQ_ABORT;
						seq_abort <= 1'b1;
						seq_hold <= 1'b0;
						abort_off <= rail_enabled;
					end else begin
						hold_cnt_reg <= hold_cnt_reg + 17'h00001;
					end
				end
				// Faults after release never pull the sequence back.
				rfi_pkg::SEQ_RUN: ;
				rfi_pkg::SEQ_ABORT: ;
			endcase
		end
	end

	assign host_reset_out_n = host_rst_n_reg;

	// ---------------------------------------------------------------
	// Interrupt sources
	// ---------------------------------------------------------------
	// Group order: status, thermal, mode, buck and linear current
	// limit, undervoltage, overvoltage, button.
	always_comb begin
		evt_raw[0] = status_evt;
		evt_raw[1] = thermal_evt;
		evt_raw[2] = mode_evt;
		evt_raw[3] = {1'b0, fault_raw.curlim.buck};
		evt_raw[4] = {4'h0, fault_raw.curlim.linear};
		evt_raw[5] = {1'b0, fault_raw.undervolt.buck};
		evt_raw[6] = {4'h0, fault_raw.undervolt.linear};
		evt_raw[7] = {1'b0, fault_raw.overvolt.buck};
		evt_raw[8] = {4'h0, fault_raw.overvolt.linear};
		evt_raw[9] = button_evt;
		// Latches take qualified faults, skipped or not.
		evt_q = evt_raw;
		evt_q[3] = {1'b0, fault_q.curlim.buck};
		evt_q[4] = {4'h0, fault_q.curlim.linear};
		evt_q[5] = {1'b0, fault_q.undervolt.buck};
		evt_q[6] = {4'h0, fault_q.undervolt.linear};
		evt_q[7] = {1'b0, fault_q.overvolt.buck};
		evt_q[8] = {4'h0, fault_q.overvolt.linear};
	end

	// Latches set on a rising source; a set in the clearing cycle wins.
	always_ff @(posedge clk) begin
		for (int g = 0; g < `RFI_NUM_GROUPS; g++) begin
			if (reset) begin
				latch_reg[g] <= `RFI_LATCH_RESET;
				evt_d_reg[g] <= 8'h00;
			end else begin
				evt_d_reg[g] <= evt_q[g];
				latch_reg[g] <= (latch_reg[g] & ~((wr_stb_reg
					&& wr_addr_reg == 8'(`RFI_LATCH_BASE + g)) ? wr_data_reg : 8'h00))
					| (evt_q[g] & ~evt_d_reg[g]);
			end
		end
	end

	// Mask registers are plain read-write.
	always_ff @(posedge clk) begin
		for (int g = 0; g < `RFI_NUM_GROUPS; g++) begin
			if (reset) begin
				mask_reg[g] <= `RFI_MASK_RESET;
			end else if (wr_stb_reg && wr_addr_reg == 8'(`RFI_MASK_BASE + g)) begin
				mask_reg[g] <= wr_data_reg;
			end
		end
	end

	// Early warning has no second level, so it latches in the summary
	// itself and is cleared by writing one to its summary bit.
	always_ff @(posedge clk) begin
		if (reset) begin
			ewarn_reg <= 1'b0;
			ewarn_d_reg <= 1'b0;
		end else begin
			ewarn_d_reg <= early_warn_evt;
			ewarn_reg <= (ewarn_reg & ~(wr_stb_reg && wr_addr_reg == `RFI_SUMMARY_OFF
				&& wr_data_reg[`RFI_EARLY_WARN_BIT])) | (early_warn_evt & ~ewarn_d_reg);
		end
	end

	// ---------------------------------------------------------------
	// Summary and interrupt pin
	// ---------------------------------------------------------------
	// Summary bits 0 to 6 are live from their groups' unmasked latches; bit 7 is the early warning latch.
	always_comb begin
		sum_next[0] = pending(latch_reg[0], mask_reg[0]);
		sum_next[1] = pending(latch_reg[1], mask_reg[1]);
		sum_next[2] = pending(latch_reg[2], mask_reg[2]);
		sum_next[3] = pending(latch_reg[3], mask_reg[3]) | pending(latch_reg[4], mask_reg[4]);
		sum_next[4] = pending(latch_reg[5], mask_reg[5]) | pending(latch_reg[6], mask_reg[6]);
		sum_next[5] = pending(latch_reg[7], mask_reg[7]) | pending(latch_reg[8], mask_reg[8]);
		sum_next[6] = pending(latch_reg[9], mask_reg[9]);
		sum_next[`RFI_EARLY_WARN_BIT] = ewarn_reg;
	end

	// Summary and pin register together, so software never sees a set
	// summary bit with the pin high or the reverse.
	always_ff @(posedge clk) begin
		if (reset) begin
			summary_reg <= 8'h00;
			irq_out_n <= 1'b1;
		end else begin
			summary_reg <= sum_next;
			irq_out_n <= ~|sum_next;
		end
	end

	// ---------------------------------------------------------------
	// Register read view
	// ---------------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		for (int g = 0; g < `RFI_NUM_GROUPS; g++) begin
			if (ptr_reg == 8'(`RFI_LATCH_BASE + g)) rd_data = latch_reg[g];
			if (ptr_reg == 8'(`RFI_MASK_BASE + g)) rd_data = mask_reg[g];
			if (ptr_reg == 8'(`RFI_LIVE_BASE + g)) rd_data = evt_raw[g] & live_mask(g);
		end
		unique case (ptr_reg)
			`RFI_SUMMARY_OFF: rd_data = summary_reg;
			`RFI_BUCK_CURLIM_SKIP_OFF: rd_data = {1'b0, skip_reg.curlim.buck};
			`RFI_LINEAR_CURLIM_SKIP_OFF: rd_data = {4'h0, skip_reg.curlim.linear};
			`RFI_BUCK_UNDERVOLT_SKIP_OFF: rd_data = {1'b0, skip_reg.undervolt.buck};
			`RFI_LINEAR_UNDERVOLT_SKIP_OFF: rd_data = {4'h0, skip_reg.undervolt.linear};
			`RFI_BUCK_OVERVOLT_SKIP_OFF: rd_data = {1'b0, skip_reg.overvolt.buck};
			`RFI_LINEAR_OVERVOLT_SKIP_OFF: rd_data = {4'h0, skip_reg.overvolt.linear};
			`RFI_SEQ_STATUS_OFF: rd_data = {4'h0, cfg_reg, seq_abort, seq_hold, host_rst_n_reg};
			default: ;
		endcase
	end

	// ---------------------------------------------------------------
	// I2C target
	// ---------------------------------------------------------------
	// Two flops per pin, then a third stage for edge detection.
	always_ff @(posedge clk) begin
		if (reset) begin
			{scl_d_reg, scl_s_reg, scl_m_reg} <= 3'h7;
			{sda_d_reg, sda_s_reg, sda_m_reg} <= 3'h7;
		end else begin
			{scl_d_reg, scl_s_reg, scl_m_reg} <= {scl_s_reg, scl_m_reg, i2c_scl_in};
			{sda_d_reg, sda_s_reg, sda_m_reg} <= {sda_s_reg, sda_m_reg, i2c_sda_in};
		end
	end

	assign scl_rise = scl_s_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s_reg & scl_d_reg;
	assign i2c_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
	assign i2c_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
	assign i2c_sda_out = 1'b0;
	assign i2c_sda_oe_n = rw_oe_n_reg;

	// Byte engine: address, pointer, then write data or read data with
	// auto-increment. Data changes only after SCL falls, so the slow
	// synchroniser delay stays inside the low half of the clock.
	always_ff @(posedge clk) begin
		if (reset) begin
			i2c_reg <= rfi_pkg::I2C_IDLE;
			bit_cnt_reg <= 4'h0;
			ack_reg <= 1'b0;
			rw_oe_n_reg <= 1'b1;
			{shift_reg, ptr_reg, wr_addr_reg, wr_data_reg} <= 32'h0;
			wr_stb_reg <= 1'b0;
		end else begin
			wr_stb_reg <= 1'b0;
			if (i2c_start) begin
				i2c_reg <= rfi_pkg::I2C_ADDR;
				bit_cnt_reg <= 4'h0;
				ack_reg <= 1'b0;
				rw_oe_n_reg <= 1'b1;
			end else if (i2c_stop) begin
				i2c_reg <= rfi_pkg::I2C_IDLE;
				ack_reg <= 1'b0;
				rw_oe_n_reg <= 1'b1;
			end else if (i2c_reg != rfi_pkg::I2C_IDLE && scl_rise) begin
				if (!ack_reg) begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					shift_reg <= {shift_reg[6:0],
						(i2c_reg == rfi_pkg::I2C_RDATA) ? 1'b0 : sda_s_reg};
				end else if (i2c_reg == rfi_pkg::I2C_RDATA && sda_s_reg) begin
					i2c_reg <= rfi_pkg::I2C_IDLE; // Controller ended the read.
				end
			end else if (i2c_reg != rfi_pkg::I2C_IDLE && scl_fall) begin
				if (ack_reg) begin
					ack_reg <= 1'b0;
					bit_cnt_reg <= 4'h0;
					rw_oe_n_reg <= 1'b1;
					if (i2c_reg == rfi_pkg::I2C_RDATA) begin
						shift_reg <= rd_data;
						rw_oe_n_reg <= rd_data[7];
						ptr_reg <= ptr_reg + 8'h01;
					end
				end else if (bit_cnt_reg == 4'h8) begin
					ack_reg <= 1'b1;
					unique case (i2c_reg)
						rfi_pkg::I2C_ADDR: begin
							if (shift_reg[7:1] == `RFI_DEV_ADDR) begin
								rw_oe_n_reg <= 1'b0;
								i2c_reg <= shift_reg[0] ? rfi_pkg::I2C_RDATA : rfi_pkg::I2C_PTR;
							end else begin
								i2c_reg <= rfi_pkg::I2C_IDLE;
							end
						end
						rfi_pkg::I2C_PTR: begin
							ptr_reg <= shift_reg;
							rw_oe_n_reg <= 1'b0;
							i2c_reg <= rfi_pkg::I2C_WDATA;
						end
						rfi_pkg::I2C_WDATA: begin
							wr_stb_reg <= 1'b1;
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= shift_reg;
							ptr_reg <= ptr_reg + 8'h01;
							rw_oe_n_reg <= 1'b0;
						end
						rfi_pkg::I2C_RDATA: rw_oe_n_reg <= 1'b1;
						rfi_pkg::I2C_IDLE: ;
					endcase
				end else if (i2c_reg == rfi_pkg::I2C_RDATA) begin
					rw_oe_n_reg <= shift_reg[7];
				end
			end
		end
	end

endmodule : rfi_top

`default_nettype wire

// *** inc/rfi_pkg.sv ***
/*
 * Types shared by the regulator fault and interrupt logic and its bench.
 * Assumes seven buck and four linear regulators.
 */
`default_nettype none

package rfi_pkg;

	// One bit per regulator, bucks and linears apart.
	typedef struct packed {
		logic [6:0] buck;
		logic [3:0] linear;
	} rfi_rail_s;

	// Current limit, undervoltage and overvoltage per regulator.
	typedef struct packed {
		rfi_rail_s curlim;
		rfi_rail_s undervolt;
		rfi_rail_s overvolt;
	} rfi_fault_s;

	typedef enum logic [1:0] {SEQ_WAIT, SEQ_HOLD, SEQ_RUN, SEQ_ABORT} rfi_seq_e;

	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WDATA, I2C_RDATA} rfi_i2c_e;

	typedef logic [7:0] rfi_byte_t;

endpackage : rfi_pkg

`default_nettype wire

// *** inc/rfi_regs.svh ***
/*
 * Register offsets, reset values and timing counts of the regulator fault
 * and interrupt logic. Assumes a 40 MHz block clock and an I2C target port.
 */
`ifndef RFI_REGS_SVH
`define RFI_REGS_SVH

// -----------------------------------------------------------------------
// Bus target identity and register map
// -----------------------------------------------------------------------
`define RFI_DEV_ADDR 7'h08
`define RFI_NUM_GROUPS 10
`define RFI_LATCH_BASE 8'h00
`define RFI_MASK_BASE 8'h10
`define RFI_LIVE_BASE 8'h20
`define RFI_SUMMARY_OFF 8'h30
`define RFI_BUCK_CURLIM_SKIP_OFF 8'h40
`define RFI_LINEAR_CURLIM_SKIP_OFF 8'h41
`define RFI_BUCK_UNDERVOLT_SKIP_OFF 8'h42
`define RFI_LINEAR_UNDERVOLT_SKIP_OFF 8'h43
`define RFI_BUCK_OVERVOLT_SKIP_OFF 8'h44
`define RFI_LINEAR_OVERVOLT_SKIP_OFF 8'h45
`define RFI_SEQ_STATUS_OFF 8'h48

// -----------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------
`define RFI_EARLY_WARN_BIT 7
`define RFI_MASK_RESET 8'h00
`define RFI_LATCH_RESET 8'h00

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define RFI_CLK_PERIOD_NS 25
`define RFI_HOLD_WIN_NS 2000000
`define RFI_HOLD_CYCLES (`RFI_HOLD_WIN_NS / `RFI_CLK_PERIOD_NS)

`endif

// *** tb/rfi_host.sv ***
/* Host controller model: drives the register port as an I2C controller.
   Assumes the bench resolves SDA with a pull-up and calls tasks at clk edges. */
`include "rfi_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rfi_host (
	// Clock
	input wire logic clk,
	// I2C lines
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	int ph = 8;
	// Idle bus: both lines released, clock standing still.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Phases of at least eight clocks leave room for the device synchronisers.
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		repeat (ph) @(posedge clk);
		scl <= 1'b1;
		repeat (ph) @(posedge clk);
		r = sda;
		scl <= 1'b0;
		@(posedge clk);
	endtask : bit_io
	// A start, or a stop when s is high; SDA is set up while SCL is low, then makes its edge while SCL is high.
	task automatic edge_c(input logic s);
		sda_drv <= s ? 1'b0 : 1'b1;
		repeat (ph) @(posedge clk);
		scl <= 1'b1;
		repeat (ph) @(posedge clk);
		sda_drv <= s;
		repeat (ph) @(posedge clk);
		scl <= s;
		@(posedge clk);
	endtask : edge_c
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, k);
	endtask : byte_io
	// Writes one register; ok is low when any byte went unacknowledged.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k0, k1, k2;
		edge_c(1'b0);
		byte_io({`RFI_DEV_ADDR, 1'b0}, 1'b1, q, k0);
		byte_io(a, 1'b1, q, k1);
		byte_io(d, 1'b1, q, k2);
		edge_c(1'b1);
		ok = !(k0 | k1 | k2);
	endtask : wr
	// Reads one register and ends the read with a NACK.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic k0, k1, k2, k3;
		edge_c(1'b0);
		byte_io({`RFI_DEV_ADDR, 1'b0}, 1'b1, q, k0);
		byte_io(a, 1'b1, q, k1);
		edge_c(1'b0);
		byte_io({`RFI_DEV_ADDR, 1'b1}, 1'b1, q, k2);
		byte_io(8'hff, 1'b1, d, k3);
		edge_c(1'b1);
		ok = !(k0 | k1 | k2);
	endtask : rd
endmodule : rfi_host
`default_nettype wire

// *** tb/rfi_top_assertions.sv ***
/* Concurrent checks on the ports of the fault and interrupt block.
   Assumes OTP inputs and the gate setting stay still within one reset run. */
`timescale 1ns/1ps
`default_nettype none
module rfi_top_assertions #(
	parameter int unsigned HOLD_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched ports
	input wire logic startup_pg_gate_cfg,
	input wire rfi_pkg::rfi_rail_s rail_enabled,
	input wire rfi_pkg::rfi_rail_s internal_power_ok,
	input wire rfi_pkg::rfi_fault_s fault_raw,
	input wire logic early_warn_evt,
	input wire logic seq_at_reset_slot,
	input wire logic host_reset_out_n,
	input wire logic seq_hold,
	input wire logic seq_abort,
	input wire rfi_pkg::rfi_fault_s rail_protect,
	input wire logic irq_out_n
);
	logic [31:0] hold_cnt;
	logic bad;
	rfi_pkg::rfi_rail_s cl_q;
	// Counts pause cycles; too long a pause to repeat.
	always_ff @(posedge clk) begin
		if (reset || !seq_hold || seq_abort) begin
			hold_cnt <= 32'h0;
		end else begin
			hold_cnt <= hold_cnt + 32'h1;
		end
	end
	// An enabled rail that is not yet in regulation.
	assign bad = |(rail_enabled & ~internal_power_ok);
	assign cl_q = fault_raw.curlim & rail_enabled;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// The sequencer waits at the release slot; the load cycle is excluded.
	sequence s_slot;
		!$past(reset) && seq_at_reset_slot && !host_reset_out_n && !seq_hold && !seq_abort;
	endsequence
	property p_release;
		s_slot ##0 (!startup_pg_gate_cfg || !bad) |=> host_reset_out_n;
	endproperty
	property p_hold;
		s_slot ##0 (startup_pg_gate_cfg && bad) |=> seq_hold && !host_reset_out_n;
	endproperty
	property p_resume;
		seq_hold && !bad |=> host_reset_out_n;
	endproperty
	property p_limit;
		hold_cnt <= HOLD_CYCLES + 32'h2;
	endproperty
	property p_abort_late;
		$rose(seq_abort) |-> hold_cnt + 32'h2 >= HOLD_CYCLES;
	endproperty
	property p_abort_sticky;
		seq_abort |=> seq_abort && !host_reset_out_n;
	endproperty
	property p_kept;
		host_reset_out_n |=> host_reset_out_n;
	endproperty
	property p_gated;
		$rose(host_reset_out_n) && startup_pg_gate_cfg |-> !$past(bad);
	endproperty
	property p_masked;
		!host_reset_out_n |=> (rail_protect.overvolt | rail_protect.undervolt) == '0;
	endproperty
	property p_curlim;
		(rail_protect.curlim & ~$past(cl_q)) == '0;
	endproperty
	property p_warn;
		$rose(early_warn_evt) |-> ##[1:3] !irq_out_n;
	endproperty
	a_release: assert property (p_release) else $error("reset not released");
	a_hold: assert property (p_hold) else $error("no pause at slot");
	a_resume: assert property (p_resume) else $error("no resume");
	a_limit: assert property (p_limit) else $error("pause too long");
	a_abort_late: assert property (p_abort_late) else $error("abort too early");
	a_abort_sticky: assert property (p_abort_sticky) else $error("abort lost");
	a_kept: assert property (p_kept) else $error("reset reasserted");
	a_gated: assert property (p_gated) else $error("released while bad");
	a_masked: assert property (p_masked) else $error("monitor not masked");
	a_curlim: assert property (p_curlim) else $error("protect without cause");
	a_warn: assert property (p_warn) else $error("no warning interrupt");
endmodule : rfi_top_assertions
bind rfi_top rfi_top_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) rfi_top_assertions_i (.clk, .reset,
	.startup_pg_gate_cfg, .rail_enabled, .internal_power_ok, .fault_raw, .early_warn_evt,
	.seq_at_reset_slot, .host_reset_out_n, .seq_hold, .seq_abort, .rail_protect, .irq_out_n);
`default_nettype wire

// *** tb/rfi_top_test.sv ***
/* Self-checking bench of the fault and interrupt block.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module rfi_top_test;
	localparam int unsigned HOLD = 20;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic scl, sda_drv, sda, i2c_sda_out, i2c_sda_oe_n, startup_pg_gate_cfg, early_warn_evt, ok;
	logic seq_at_reset_slot, host_reset_out_n, seq_hold, seq_abort, power_good_pin, irq_out_n;
	logic [7:0] status_evt, thermal_evt, mode_evt, button_evt, q, b;
	rfi_pkg::rfi_fault_s otp_skip, fault_raw, rail_protect;
	rfi_pkg::rfi_rail_s rail_enabled, rail_blank_done, internal_power_ok, abort_off;
	logic [7:0] ga[4] = '{8'h00, 8'h01, 8'h02, 8'h09};
	logic [7:0] sb[4] = '{8'h01, 8'h02, 8'h04, 8'h40};
	logic [7:0] lv[4] = '{8'h07, 8'hff, 8'h00, 8'h81};
	integer n_errors = 0;
	integer n_tests = 0;
	integer seed = 32'h7fe9;
	integer k;
	// Open-drain data line with a pull-up.
	assign sda = sda_drv & (i2c_sda_oe_n | i2c_sda_out);
	always #12.5 clk = ~clk;
	rfi_top #(.HOLD_CYCLES(HOLD)) rfi_top_i (.clk, .reset, .i2c_scl_in(scl), .i2c_sda_in(sda),
		.i2c_sda_out, .i2c_sda_oe_n, .otp_skip, .startup_pg_gate_cfg, .rail_enabled,
		.rail_blank_done, .internal_power_ok, .fault_raw, .status_evt, .thermal_evt, .mode_evt,
		.button_evt, .early_warn_evt, .seq_at_reset_slot, .host_reset_out_n, .seq_hold,
		.seq_abort, .abort_off, .rail_protect, .power_good_pin, .irq_out_n);
	rfi_host rfi_host_i (.clk, .scl, .sda_drv, .sda);
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rfi_host_i.rd(a, q, ok);
		chk("read ack", 1'b1, ok);
		chk($sformatf("register %h", a), e, q);
	endtask : rchk
	task automatic wchk(input logic [7:0] a, input logic [7:0] d);
		rfi_host_i.wr(a, d, ok);
		chk("write ack", 1'b1, ok);
	endtask : wchk
	// Reset also checks the outputs held while it lasts.
	task automatic restart(input logic c);
		reset <= 1'b1;
		startup_pg_gate_cfg <= c;
		repeat (2) @(posedge clk);
		chk("reset outputs", 5'h03, {host_reset_out_n, power_good_pin, seq_abort, irq_out_n,
			i2c_sda_oe_n});
		reset <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : restart
	// Expected skip register contents, bucks in bits 6:0 and linears in 3:0.
	function automatic logic [7:0] skip_of(input int i);
		rfi_pkg::rfi_rail_s r;
		r = (i < 2) ? otp_skip.curlim : (i < 4) ? otp_skip.undervolt : otp_skip.overvolt;
		return i[0] ? {4'h0, r.linear} : {1'b0, r.buck};
	endfunction : skip_of
	task automatic complete_run();
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// Stops a hang; the tests need about 66000 clocks.
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		complete_run();
	end
	initial begin
		{status_evt, thermal_evt, mode_evt, button_evt, early_warn_evt, seq_at_reset_slot} = '0;
		{otp_skip, fault_raw, rail_enabled, rail_blank_done, internal_power_ok} = '0;
		startup_pg_gate_cfg = 1'b0;
		// Release gating: unchecked, paused then resumed, paused then aborted.
		for (int m = 0; m < 3; m++) begin
			restart(m != 0);
			k = $unsigned($random(seed)) % 11;
			rail_enabled <= 11'($random(seed)) | (11'h1 << k);
			internal_power_ok <= ~(11'h1 << k);
			seq_at_reset_slot <= 1'b1;
			repeat (5) @(posedge clk);
			chk("pause", m != 0, seq_hold);
			chk("host reset", m == 0, host_reset_out_n);
			internal_power_ok <= (m == 1) ? '1 : internal_power_ok;
			repeat (HOLD + 5) @(posedge clk);
			chk("abort", m == 2, seq_abort);
			chk("rails off", (m == 2) ? rail_enabled : 11'h0, abort_off);
			chk("host reset", m != 2, host_reset_out_n);
			seq_at_reset_slot <= 1'b0;
		end
		// Faults on every rail with random skip bits, then with all bypassed.
		for (int v = 0; v < 2; v++) begin
			otp_skip <= v ? '1 : 33'({$random(seed), $random(seed)});
			rail_enabled <= '1;
			rail_blank_done <= '1;
			internal_power_ok <= '1;
			restart(1'b0);
			seq_at_reset_slot <= 1'b1;
			for (int i = 0; i < 6; i++) begin
				rchk(8'h40 + 8'(i), skip_of(i));
			end
			fault_raw <= '1;
			repeat (4) @(posedge clk);
			chk("protect", ~otp_skip, rail_protect);
			chk("power good", &(otp_skip.overvolt & otp_skip.undervolt), power_good_pin);
			chk("irq", 1'b0, irq_out_n);
			for (int g = 3; g < 9; g++) begin
				rchk(8'(g), g[0] ? 8'h7f : 8'h0f);
			end
			rchk(8'h30, 8'h38);
			for (int g = 3; g < 9; g++) begin
				wchk(8'(g), 8'hff);
			end
			rchk(8'h30, 8'h00);
			chk("irq", 1'b1, irq_out_n);
			fault_raw <= '0;
		end
		// Status, thermal, mode and button groups masked, unmasked and cleared, with a slower host.
		for (int j = 0; j < 4; j++) begin
			rfi_host_i.ph = 8 + 4 * j;
			b = 8'h1 << ($unsigned($random(seed)) % ((j == 2) ? 7 : 8));
			wchk(8'h10 + ga[j], b);
			{button_evt, mode_evt, thermal_evt, status_evt} <= 32'(b) << (8 * j);
			repeat (4) @(posedge clk);
			chk("irq", 1'b1, irq_out_n);
			rchk(ga[j], b);
			rchk(8'h30, 8'h00);
			rchk(8'h20 + ga[j], b & lv[j]);
			wchk(8'h10 + ga[j], 8'h00);
			chk("irq", 1'b0, irq_out_n);
			rchk(8'h30, sb[j]);
			wchk(ga[j], b);
			rchk(ga[j], 8'h00);
			chk("irq", 1'b1, irq_out_n);
			{button_evt, mode_evt, thermal_evt, status_evt} <= '0;
		end
		// Early warning raises bit 7 alone; unmapped places read zero.
		early_warn_evt <= 1'b1;
		repeat (4) @(posedge clk);
		chk("irq", 1'b0, irq_out_n);
		rchk(8'h30, 8'h80);
		wchk(8'h30, 8'h80);
		rchk(8'h30, 8'h00);
		chk("irq", 1'b1, irq_out_n);
		rchk(8'h3f, 8'h00);
		complete_run();
	end
endmodule : rfi_top_test
`default_nettype wire
